// ===== hdl/iaf_map.svh
`ifndef IAF_MAP_SVH
`define IAF_MAP_SVH
`define IAF_ACT_IDX 20'h1c017
`define IAF_FLT_IDX 20'h41333
`define IAF_OPT_IDX 20'h41eab
`define IAF_CTL_IDX 20'h41eac
`define IAF_STA_IDX 20'h41ead
`define IAF_ACT_SPAN 20'd64
`define IAF_FLT_SPAN 20'd212
`define IAF_PORTS 6'd53
`define IAF_OPT_RST 4'h4
`define IAF_UTPID_RST 16'h0000
`define IAF_TPID_C 16'h8100
`define IAF_TPID_S 16'h88a8
`endif

// ===== hdl/iaf_pkg.sv
package iaf_pkg;
  typedef struct packed {
    logic ivid_prio;
    logic [11:0] ingress_vlan_value;
    logic ingress_vlan_override;
    logic queue_prio;
    logic [2:0] queue_choice;
    logic queue_override;
    logic [1:0] policer_ref_order;
    logic [6:0] policer_ref;
    logic policer_ref_valid;
    logic colour_prio;
    logic [1:0] colour;
    logic colour_override;
    logic tpid_prio;
    logic ovid_prio;
    logic pcp_prio;
    logic dei_prio;
    logic [1:0] tag_type_select;
    logic tag_type_rewrite;
    logic [11:0] ovid;
    logic vlan_id_rewrite;
    logic [2:0] pcp;
    logic priority_code_rewrite;
    logic dei;
    logic drop_eligible_rewrite;
    logic [7:0] counter_idx;
    logic count_flag;
    logic suppress_address_learn;
    logic copy_out_precedence;
    logic [5:0] copy_out_target;
    logic copy_out_flag;
    logic [5:0] redirect_target;
    logic port_redirect_flag;
    logic discard_flag;
    logic hop_limit_decrement;
    logic redirect_to_processor;
    logic addr_rewrite_precedence;
    logic [8:0] addr_rewrite_index;
    logic addr_rewrite_flag;
  } iaf_act_s;
  typedef struct packed {
    logic [52:0] origin_port_block_mask;
    logic ss, cc, sc, cs, dual, l2mc, flood_discard, l2bc;
    logic v6mc, v4mc, mpls, v6, v4, untag, single;
    logic multi_tag_qualifier, s1, c1;
  } iaf_flt_s;
  typedef struct packed {
    logic valid;
    logic [7:0] ttl;
    logic l2_drop;
    logic [3:0] cause;
  } iaf_req_s;
  typedef struct packed {
    logic valid, to_cpu, drop, learn;
    logic [7:0] ttl;
    logic port_v;
    logic [5:0] port;
    logic mir_v;
    logic [5:0] mir;
    logic cnt_v;
    logic [7:0] cnt;
    logic mac_v;
    logic [8:0] mac;
    logic dei_v, dei, pcp_v;
    logic [2:0] pcp;
    logic vid_v;
    logic [11:0] vid;
    logic tpid_v;
    logic [15:0] tpid;
    logic col_v;
    logic [1:0] col;
    logic pol_v;
    logic [6:0] pol;
    logic [1:0] pol_ord;
    logic q_v;
    logic [2:0] q;
    logic ivid_v;
    logic [11:0] ivid;
  } iaf_res_s;
  typedef struct packed {
    logic valid, l2l3;
    logic [5:0] eport, sport;
    logic [1:0] ntag;
    logic outer_s, inner_s, pushed, v4, v6, mpls;
    logic v4mc, v6mc, l2bc, flood, l2mc;
  } iaf_egq_s;
endpackage

// ===== hdl/iaf_top.sv
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "iaf_map.svh"
module iaf_top #(
  parameter int N_RES = 2
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire iaf_pkg::iaf_req_s LK_REQ,
  input wire logic [N_RES*16-1:0] LK_MATCH,
  output iaf_pkg::iaf_res_s RES,
  input wire iaf_pkg::iaf_egq_s EGQ,
  output logic EG_VALID,
  output logic EG_DROP
);
  import iaf_pkg::*;
  localparam int NT = 16;

  iaf_act_s act_tab [16];
  iaf_flt_s flt_tab [53];
  logic [3:0] opt;
  logic [15:0] utpid;
  logic ctl_cpu;
  logic [15:0] cls_cnt, eg_cnt;
  logic wr_en;
  logic [19:0] wr_idx, wa, wf, ra, rf;
  logic acc;
  logic [31:0] rd;
  logic [127:0] rt;
  logic [1:0] rw;

  function automatic logic [97:0] put_a(input logic [97:0] o, input logic [1:0] w, input logic [31:0] d);
    logic [127:0] t;
    t = {30'h0, o};
    t[w*32 +: 32] = d;
    put_a = t[97:0];
  endfunction

  function automatic logic [70:0] put_f(input logic [70:0] o, input logic [1:0] w, input logic [31:0] d);
    logic [127:0] t;
    t = {57'h0, o};
    t[w*32 +: 32] = d;
    put_f = t[70:0];
  endfunction

  // zero-wait slave, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign acc = HSEL & HTRANS[1] & HREADY;
  assign ra = HADDR[21:2] - `IAF_ACT_IDX;
  assign rf = HADDR[21:2] - `IAF_FLT_IDX;
  assign wa = wr_idx - `IAF_ACT_IDX;
  assign wf = wr_idx - `IAF_FLT_IDX;

  always_comb begin
    rt = '0;
    rw = 2'h0;
    if (ra < `IAF_ACT_SPAN) begin
      rt = {30'h0, act_tab[ra[5:2]]};
      rw = ra[1:0];
    end else if (rf < `IAF_FLT_SPAN) begin
      rt = {57'h0, flt_tab[rf[7:2]]};
      rw = rf[1:0];
    end else if (HADDR[21:2] == `IAF_OPT_IDX) begin
      rt[3:0] = opt;
    end else if (HADDR[21:2] == `IAF_CTL_IDX) begin
      rt[16:0] = {ctl_cpu, utpid};
    end else if (HADDR[21:2] == `IAF_STA_IDX) begin
      rt[31:0] = {eg_cnt, cls_cnt};
    end
    rd = rt[rw*32 +: 32];
  end

  // address phase captured, write lands in data phase
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_en <= 1'b0;
      wr_idx <= '0;
      HRDATA <= '0;
    end else begin
      wr_en <= acc & HWRITE;
      if (acc) begin
        wr_idx <= HADDR[21:2];
      end
      if (acc & ~HWRITE) begin
        HRDATA <= rd;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int e = 0; e < 16; e++) begin
        act_tab[e] <= '0;
      end
      for (int e = 0; e < 53; e++) begin
        flt_tab[e] <= '0;
      end
    end else if (wr_en) begin
      if (wa < `IAF_ACT_SPAN) begin
        act_tab[wa[5:2]] <= put_a(act_tab[wa[5:2]], wa[1:0], HWDATA);
      end
      if (wf < `IAF_FLT_SPAN) begin
        flt_tab[wf[7:2]] <= put_f(flt_tab[wf[7:2]], wf[1:0], HWDATA);
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      opt <= `IAF_OPT_RST;
      utpid <= `IAF_UTPID_RST;
      ctl_cpu <= 1'b0;
    end else if (wr_en) begin
      if (wr_idx == `IAF_OPT_IDX) begin
        opt <= HWDATA[3:0];
      end
      if (wr_idx == `IAF_CTL_IDX) begin
        {ctl_cpu, utpid} <= HWDATA[16:0];
      end
    end
  end

  // lookup: per result hit decode and entry read
  logic [N_RES-1:0] hv;
  iaf_act_s [N_RES-1:0] ent;
  logic [N_RES-1:0] fl [NT];
  logic [N_RES-1:0] pr [NT];
  logic [N_RES-1:0] oh [NT];
  iaf_act_s sel [NT];

  for (genvar i = 0; i < N_RES; i++) begin : g_hit
    logic [3:0] hi;
    always_comb begin
      hi = 4'h0;
      for (int k = 15; k >= 0; k--) begin
        if (LK_MATCH[i*16+k]) begin
          hi = 4'(k);
        end
      end
    end
    assign hv[i] = LK_REQ.valid & (|LK_MATCH[i*16 +: 16]);
    assign ent[i] = act_tab[hi];
  end

  always_comb begin
    for (int t = 0; t < NT; t++) begin
      fl[t] = '0;
      pr[t] = '0;
    end
    for (int i = 0; i < N_RES; i++) begin
      fl[0][i] = hv[i] & ent[i].addr_rewrite_flag;
      pr[0][i] = ent[i].addr_rewrite_precedence;
      fl[1][i] = hv[i] & ent[i].copy_out_flag;
      pr[1][i] = ent[i].copy_out_precedence;
      fl[2][i] = hv[i] & ent[i].drop_eligible_rewrite;
      pr[2][i] = ent[i].dei_prio;
      fl[3][i] = hv[i] & ent[i].priority_code_rewrite;
      pr[3][i] = ent[i].pcp_prio;
      fl[4][i] = hv[i] & ent[i].vlan_id_rewrite;
      pr[4][i] = ent[i].ovid_prio;
      fl[5][i] = hv[i] & ent[i].tag_type_rewrite;
      pr[5][i] = ent[i].tpid_prio;
      fl[6][i] = hv[i] & ent[i].colour_override;
      pr[6][i] = ent[i].colour_prio;
      fl[7][i] = hv[i] & ent[i].queue_override;
      pr[7][i] = ent[i].queue_prio;
      fl[8][i] = hv[i] & ent[i].ingress_vlan_override;
      pr[8][i] = ent[i].ivid_prio;
      fl[9][i] = hv[i] & ent[i].port_redirect_flag;
      fl[10][i] = hv[i] & ent[i].count_flag;
      fl[11][i] = hv[i] & ent[i].policer_ref_valid;
      fl[12][i] = hv[i] & ent[i].redirect_to_processor;
      fl[13][i] = hv[i] & ent[i].discard_flag;
      fl[14][i] = hv[i] & ent[i].hop_limit_decrement;
      fl[15][i] = hv[i] & ent[i].suppress_address_learn;
    end
  end

  for (genvar t = 0; t < NT; t++) begin : g_sel
    logic [N_RES-1:0] c;
    always_comb begin
      c = (|(fl[t] & pr[t])) ? (fl[t] & pr[t]) : fl[t];
      oh[t] = c & (~c + 1'b1);
      sel[t] = '0;
      for (int i = 0; i < N_RES; i++) begin
        if (oh[t][i]) begin
          sel[t] = ent[i];
        end
      end
    end
  end

  iaf_res_s next_res;
  logic ttl_exp;
  always_comb begin
    next_res = '0;
    next_res.valid = LK_REQ.valid;
    next_res.ttl = LK_REQ.ttl;
    if (|fl[14] && LK_REQ.ttl != 8'h0) begin
      next_res.ttl = LK_REQ.ttl - 8'h1;
    end
    ttl_exp = (|fl[14]) && next_res.ttl == 8'h0;
    next_res.to_cpu = (|fl[12]) | (ttl_exp & ctl_cpu);
    next_res.drop = (|fl[13]) | (ttl_exp & ~ctl_cpu);
    next_res.learn = LK_REQ.valid & ~(|fl[15]) & (~LK_REQ.l2_drop | (|(LK_REQ.cause & opt)));
    next_res.port_v = |fl[9];
    next_res.port = sel[9].redirect_target;
    next_res.mir_v = |fl[1];
    next_res.mir = sel[1].copy_out_target;
    next_res.cnt_v = |fl[10];
    next_res.cnt = sel[10].counter_idx;
    next_res.mac_v = |fl[0];
    next_res.mac = sel[0].addr_rewrite_index;
    next_res.dei_v = |fl[2];
    next_res.dei = sel[2].dei;
    next_res.pcp_v = |fl[3];
    next_res.pcp = sel[3].pcp;
    next_res.vid_v = |fl[4];
    next_res.vid = sel[4].ovid;
    // select 3 is unused: no rewrite
    next_res.tpid_v = (|fl[5]) && sel[5].tag_type_select != 2'd3;
    case (sel[5].tag_type_select)
      2'd0: next_res.tpid = `IAF_TPID_C;
      2'd1: next_res.tpid = `IAF_TPID_S;
      default: next_res.tpid = utpid;
    endcase
    next_res.col_v = |fl[6];
    next_res.col = sel[6].colour;
    next_res.pol_v = |fl[11];
    next_res.pol = sel[11].policer_ref;
    next_res.pol_ord = sel[11].policer_ref_order;
    next_res.q_v = |fl[7];
    next_res.q = sel[7].queue_choice;
    next_res.ivid_v = |fl[8];
    next_res.ivid = sel[8].ingress_vlan_value;
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RES <= '0;
    end else begin
      RES <= next_res;
    end
  end

  // egress packet type filter
  iaf_flt_s fe;
  logic ot_s, one, two, next_drop;
  always_comb begin
    fe = (EGQ.eport < `IAF_PORTS) ? flt_tab[EGQ.eport] : '0;
    ot_s = EGQ.outer_s & ~EGQ.pushed;
    one = EGQ.ntag == 2'd1;
    two = EGQ.ntag[1];
    next_drop = (fe.c1 & fe.multi_tag_qualifier & one & ~ot_s)
      | (fe.s1 & fe.multi_tag_qualifier & one & ot_s)
      | (fe.single & one) | (fe.untag & EGQ.ntag == 2'd0)
      | (fe.dual & two)
      | (fe.cs & two & ~ot_s & EGQ.inner_s)
      | (fe.sc & two & ot_s & ~EGQ.inner_s)
      | (fe.cc & two & ~ot_s & ~EGQ.inner_s)
      | (fe.ss & two & ot_s & EGQ.inner_s)
      | (fe.v4 & EGQ.v4) | (fe.v6 & EGQ.v6) | (fe.mpls & EGQ.mpls)
      | (fe.v4mc & EGQ.v4mc) | (fe.v6mc & EGQ.v6mc)
      | (fe.l2bc & EGQ.l2bc) | (fe.flood_discard & EGQ.flood) | (fe.l2mc & EGQ.l2mc)
      | (EGQ.sport < `IAF_PORTS && fe.origin_port_block_mask[EGQ.sport]);
    next_drop = next_drop & EGQ.valid & EGQ.l2l3;
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      EG_VALID <= 1'b0;
      EG_DROP <= 1'b0;
    end else begin
      EG_VALID <= EGQ.valid;
      EG_DROP <= next_drop;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cls_cnt <= '0;
      eg_cnt <= '0;
    end else begin
      if (|fl[13]) begin
        cls_cnt <= cls_cnt + 16'h1;
      end
      if (next_drop) begin
        eg_cnt <= eg_cnt + 16'h1;
      end
    end
  end

  AST_HIT: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    LK_REQ.valid && LK_MATCH[15:0] == 16'h0004 && $onehot(fl[10]) && fl[10][0]
    |=> RES.cnt_v && RES.cnt == $past(act_tab[2].counter_idx))
    else $error("counter index not from hit entry");

  AST_LOW: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    fl[9][0] |=> RES.port_v && RES.port == $past(ent[0].redirect_target))
    else $error("lowest hit not chosen for port");

  if (N_RES > 1) begin : g_ast
    AST_PRIO: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      fl[4][0] && fl[4][1] && pr[4][1] && !pr[4][0]
      |=> RES.vid_v && RES.vid == $past(ent[1].ovid))
      else $error("precedence bit ignored");
  end

  AST_TTL: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (|fl[14]) && LK_REQ.ttl == 8'h1
    |=> RES.ttl == 8'h0 && (RES.drop != RES.to_cpu || (RES.drop && RES.to_cpu)))
    else $error("expired hop limit not handled");

  AST_DCNT: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    |fl[13] |=> RES.drop && cls_cnt == $past(cls_cnt) + 16'h1)
    else $error("discard not counted");

  AST_LEARN: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    LK_REQ.valid && LK_REQ.l2_drop && (LK_REQ.cause & opt) == 4'h0 |=> !RES.learn)
    else $error("learned on disallowed drop");

  AST_BYP: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    EGQ.valid && !EGQ.l2l3 |=> EG_VALID && !EG_DROP)
    else $error("bypass traffic filtered");

  AST_ECNT: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    EG_DROP |-> eg_cnt == $past(eg_cnt) + 16'h1)
    else $error("egress drop not counted");

  AST_SRC: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    EGQ.valid && EGQ.l2l3 && EGQ.sport < `IAF_PORTS && fe.origin_port_block_mask[EGQ.sport]
    |=> EG_DROP)
    else $error("blocked source passed");

  AST_TPID: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (|fl[5]) && sel[5].tag_type_select == 2'd1 |=> RES.tpid_v && RES.tpid == `IAF_TPID_S)
    else $error("wrong tag type");

endmodule // iaf_top

// ===== tb/iaf_far.sv
`timescale 1ns/100ps
module iaf_far (
  input wire logic clk,
  output iaf_pkg::iaf_req_s req,
  output logic [31:0] mt,
  output iaf_pkg::iaf_egq_s eq
);
  import iaf_pkg::*;
  initial begin
    req = '0;
    mt = '0;
    eq = '0;
  end
  // gap 0 leaves the next request back to back; released lines show the inverse
  task automatic lk(input iaf_req_s r, input logic [31:0] m, input int gap);
    iaf_req_s t;
    @(posedge clk);
    req <= r;
    mt <= m;
    if (gap > 0) begin
      @(posedge clk);
      t = ~r;
      t.valid = 1'b0;
      req <= t;
      mt <= ~m;
      repeat (gap - 1) @(posedge clk);
    end
  endtask
  // l2l3, flood and l2mc are settled by the upstream stages
  task automatic eg(input iaf_egq_s e, input int gap);
    iaf_egq_s t;
    @(posedge clk);
    eq <= e;
    if (gap > 0) begin
      @(posedge clk);
      t = ~e;
      t.valid = 1'b0;
      eq <= t;
      repeat (gap - 1) @(posedge clk);
    end
  endtask
endmodule // iaf_far

// ===== tb/tb.sv
`timescale 1ns/100ps
`include "iaf_map.svh"
module tb;
  import iaf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hrdy;
  logic hresp;
  logic [31:0] hrdata;
  iaf_req_s lreq;
  logic [31:0] lmt;
  iaf_res_s res;
  iaf_egq_s egq;
  logic eg_valid;
  logic eg_drop;
  logic [97:0] act [16];
  iaf_flt_s flt [8];
  logic [97:0] a0;
  logic [97:0] a1;
  logic [3:0] opt = 4'h4;
  logic [31:0] ctl = 32'h0;
  logic [15:0] dcnt = 16'h0;
  logic [15:0] ecnt = 16'h0;
  iaf_res_s rq [$];
  logic dq [$];
  integer seed = 32'hb37a277a;
  int mismatches = 0;
  int n_checks = 0;
  logic [31:0] q;
  logic [127:0] v;

  always #4 clk = ~clk;

  iaf_top #(.N_RES(2)) u_dut (
    .SYS_CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HREADYOUT(hrdy),
    .HRESP(hresp), .HRDATA(hrdata), .LK_REQ(lreq), .LK_MATCH(lmt), .RES(res),
    .EGQ(egq), .EG_VALID(eg_valid), .EG_DROP(eg_drop)
  );
  iaf_far u_far (.clk(clk), .req(lreq), .mt(lmt), .eq(egq));

  task automatic bad(input string s);
    mismatches++;
    $display("BAD %0t %s", $time, s);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) bad($sformatf("reg %h want %h", g, e));
  endtask
  task automatic chkr(input iaf_res_s g, input iaf_res_s e);
    n_checks++;
    if (g !== e) bad($sformatf("result %h want %h", g, e));
  endtask
  task automatic chke(input logic [1:0] g, input logic [1:0] e);
    n_checks++;
    if (g !== e) bad($sformatf("egress %b want %b", g, e));
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [19:0] ix, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {10'h0, ix, 2'h0};
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
    if (hresp !== 1'b0) bad("error response");
  endtask

  function automatic logic [127:0] rnd();
    return {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction

  // winner among flagged results: precedence bit first, then lowest index
  function automatic logic [16:0] win(input int f, input int p, input int lo, input int wd);
    logic [1:0] s;
    logic [97:0] x;
    s = {a1[f], a0[f]};
    if (({a1[p], a0[p]} & s) != 0) s = {a1[p], a0[p]} & s;
    x = s[0] ? a0 : s[1] ? a1 : 98'h0;
    return (17'(x >> lo) & ((17'h1 << wd) - 17'h1)) | (17'(s != 0) << wd);
  endfunction

  function automatic iaf_res_s ex(input iaf_req_s r, input logic [31:0] m);
    iaf_res_s e;
    logic [16:0] t;
    logic dec;
    a0 = '0;
    a1 = '0;
    for (int k = 15; k >= 0; k--) begin
      if (m[k]) a0 = act[k];
      if (m[16+k]) a1 = act[k];
    end
    e = '0;
    e.valid = 1'b1;
    dec = a0[12] | a1[12];
    e.ttl = (dec && r.ttl != 0) ? r.ttl - 8'h1 : r.ttl;
    e.to_cpu = a0[11] | a1[11] | (dec && e.ttl == 0 && ctl[16]);
    e.drop = a0[13] | a1[13] | (dec && e.ttl == 0 && !ctl[16]);
    e.learn = !(a0[29] | a1[29]) && (!r.l2_drop || (r.cause & opt) != 0);
    {e.mac_v, e.mac} = 10'(win(0, 10, 1, 9));
    {e.port_v, e.port} = 7'(win(14, 14, 15, 6));
    {e.mir_v, e.mir} = 7'(win(21, 28, 22, 6));
    {e.cnt_v, e.cnt} = 9'(win(30, 30, 31, 8));
    {e.dei_v, e.dei} = 2'(win(39, 61, 40, 1));
    {e.pcp_v, e.pcp} = 4'(win(41, 62, 42, 3));
    {e.vid_v, e.vid} = 13'(win(45, 63, 46, 12));
    t = win(58, 64, 59, 2);
    // select 3 leaves the tag type alone; unflagged results carry select 0
    e.tpid_v = t[2] && t[1:0] != 2'h3;
    e.tpid = t[1:0] == 2'h0 ? `IAF_TPID_C : t[1:0] == 2'h1 ? `IAF_TPID_S : ctl[15:0];
    {e.col_v, e.col} = 3'(win(65, 68, 66, 2));
    t = win(69, 69, 70, 9);
    {e.pol_v, e.pol, e.pol_ord} = {t[9], t[6:0], t[8:7]};
    {e.q_v, e.q} = 4'(win(79, 83, 80, 3));
    {e.ivid_v, e.ivid} = 13'(win(84, 97, 85, 12));
    return e;
  endfunction

  function automatic logic fd(input iaf_egq_s g);
    iaf_flt_s f;
    logic oc;
    logic ic;
    if (!g.l2l3 || g.eport >= 6'd8) return 1'b0;
    f = flt[g.eport[2:0]];
    oc = !g.outer_s || g.pushed;
    ic = !g.inner_s;
    return (g.sport < 6'd53 && f.origin_port_block_mask[g.sport])
      || (g.ntag == 2'd0 && f.untag) || (g.ntag == 2'd1 && (f.single || (oc ? f.c1 : f.s1)))
      || (g.ntag == 2'd2 && (f.dual || (oc && !ic && f.cs) || (!oc && ic && f.sc) || (oc && ic && f.cc)
      || (!oc && !ic && f.ss)))
      || |({g.v4, g.v6, g.mpls, g.v4mc, g.v6mc} & {f.v4, f.v6, f.mpls, f.v4mc, f.v6mc})
      || |({g.l2bc, g.flood, g.l2mc} & {f.l2bc, f.flood_discard, f.l2mc});
  endfunction

  always @(posedge clk) begin
    if (lreq.valid === 1'b1) begin
      rq.push_back(ex(lreq, lmt));
      dcnt = dcnt + 16'(a0[13] | a1[13]);
    end
    if (egq.valid === 1'b1) begin
      dq.push_back(fd(egq));
      ecnt = ecnt + 16'(dq[$]);
    end
  end
  always @(negedge clk) begin
    if (rq.size() > 0) chkr(res, rq.pop_front());
    else if (res.valid !== 1'b0) bad("stray result");
    if (dq.size() > 0) chke({eg_valid, eg_drop}, {1'b1, dq.pop_front()});
    else if (eg_valid !== 1'b0) bad("stray egress");
  end

  task automatic lk_one(input logic last);
    iaf_req_s r;
    logic [31:0] m;
    r = 14'($random(seed));
    r.valid = 1'b1;
    if (r.ttl < 8'd2) r.ttl = 8'd1;
    m = $random(seed) & $random(seed);
    if (r.cause[0]) m[15:0] = 16'h0;
    u_far.lk(r, m, last ? 1 : {$random(seed)} % 3);
  endtask
  task automatic eg_one(input logic last);
    iaf_egq_s g;
    g = 27'($random(seed));
    g.valid = 1'b1;
    g.ntag = 2'({$random(seed)} % 3);
    if (g.sport[0]) g.eport[5:3] = 3'h0;
    u_far.eg(g, last ? 1 : {$random(seed)} % 3);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, `IAF_OPT_IDX, 32'h0, q);
    chk(q, {28'h0, `IAF_OPT_RST});
    bus(1'b0, `IAF_STA_IDX + 20'h1, 32'h0, q);
    chk(q, 32'h0);
    opt = 4'($random(seed));
    bus(1'b1, `IAF_OPT_IDX, {28'h0, opt}, q);
    bus(1'b0, `IAF_OPT_IDX, 32'h0, q);
    chk(q, {28'h0, opt});
    for (int e = 0; e < 16; e++) begin
      v = rnd();
      v[127:98] = '0;
      // entry 2 always counts and decrements, for the hit-index corner case
      if (e == 2) {v[30], v[12]} = 2'h3;
      act[e] = v[97:0];
      for (int w = 0; w < 4; w++) bus(1'b1, `IAF_ACT_IDX + 20'(4 * e + w), v[w*32+:32], q);
    end
    bus(1'b0, `IAF_ACT_IDX + 20'd63, 32'h0, q);
    chk(q, {30'h0, act[15][97:96]});
    for (int p = 0; p < 8; p++) begin
      v = rnd() & rnd() & rnd();
      v[127:71] = '0;
      if (v[0] | v[1]) v[2] = 1'b1;
      flt[p] = v[70:0];
      for (int w = 0; w < 3; w++) bus(1'b1, `IAF_FLT_IDX + 20'(4 * p + w), v[w*32+:32], q);
    end
    bus(1'b0, `IAF_FLT_IDX + 20'd30, 32'h0, q);
    chk(q, {25'h0, flt[7][70:64]});
    $display("register test done");
    for (int k = 0; k < 2; k++) begin
      ctl = {15'h0, 1'(k), 16'($random(seed))};
      bus(1'b1, `IAF_CTL_IDX, ctl, q);
      // hit on entry 2 of result 0 only, hop limit 1
      u_far.lk(14'h2020, 32'h0000_0004, 1);
      fork
        for (int i = 0; i < 150; i++) lk_one(i == 149);
        for (int i = 0; i < 150; i++) eg_one(i == 149);
      join
      repeat (2) @(posedge clk);
      $display("traffic pass %0d done", k);
    end
    bus(1'b0, `IAF_STA_IDX, 32'h0, q);
    chk(q, {ecnt, dcnt});
    bus(1'b1, `IAF_STA_IDX, ~q, q);
    bus(1'b0, `IAF_STA_IDX, 32'h0, q);
    chk(q, {ecnt, dcnt});
    $display("counter test done");
    end_sim();
  end

  initial begin
    #200000;
    bad("timeout");
    end_sim();
  end
endmodule // tb
